// ==== hdl/cca_defs.svh ====
`ifndef CCA_DEFS_SVH
`define CCA_DEFS_SVH
// Register byte addresses (one aligned word each)
`define CCA_A_CNT_LO    12'h000
`define CCA_A_CNT_HI    12'h004
`define CCA_A_MODE      12'h008
`define CCA_A_CTRL      12'h00C
`define CCA_A_IRQEN     12'h010
`define CCA_A_MMODE0    12'h020
`define CCA_A_MLO0      12'h040
`define CCA_A_MHI0      12'h060
`define CCA_A_STRIDE    12'h004
// Mode register fields
`define CCA_MD_OVF      0
`define CCA_MD_OVFIE    1
`define CCA_MD_TB_LO    2
`define CCA_MD_TB_HI    4
`define CCA_MD_GUARD    5
`define CCA_MD_IDLE     7
// Control register fields
`define CCA_CN_RUN      6
`define CCA_CN_OVF      7
// Module mode register fields
`define CCA_MM_IRQ      0
`define CCA_MM_PWM      1
`define CCA_MM_TOG      2
`define CCA_MM_MAT      3
`define CCA_MM_FALL     4
`define CCA_MM_RISE     5
`define CCA_MM_CMP      6
`define CCA_MM_WIDE     7
// Reset values
`define CCA_MODE_RST    8'h20
`define CCA_ZERO8       8'h00
`define CCA_ZERO16      16'h0000
`define CCA_ONES16      16'hFFFF
// Prescale counts
`define CCA_DIV12       4'hB
`define CCA_DIV4        4'h3
`define CCA_DIV8        3'h7
`define CCA_GUARD_MOD   4
`endif

// ==== hdl/cca_pkg.sv ====
package cca_pkg;
	typedef enum logic [2:0] {
		CCA_TB_DIV12,
		CCA_TB_DIV4,
		CCA_TB_T0OVF,
		CCA_TB_EXTIN,
		CCA_TB_SYS,
		CCA_TB_OSC8
	} cca_tb_t;
	typedef enum {
		CCA_M_OFF,
		CCA_M_CAPTURE,
		CCA_M_SWTIMER,
		CCA_M_HSOUT,
		CCA_M_FREQ,
		CCA_M_PWM8,
		CCA_M_PWM16
	} cca_mode_t;
endpackage

// ==== hdl/cca_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser plus a qualifier that accepts a level only once it
// has stood for two clocks, so one-cycle glitches never form an edge.
module cca_edge (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic raw_in,
	output logic      rise_p,
	output logic      fall_p
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				lvl_q <= s3_q;
		end
	end

	assign rise_p = (s2_q == s3_q) && s3_q && !lvl_q;
	assign fall_p = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule // cca_edge
`default_nettype wire

// ==== hdl/cca_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cca_defs.svh"
// Timebase selector producing one count-enable pulse per counter step.
module cca_tick (
	input  wire logic            sys_clk,
	input  wire logic            sys_rst,
	input  wire cca_pkg::cca_tb_t sel,
	input  wire logic            t0_ovf,
	input  wire logic            ext_fall,
	input  wire logic            osc_div8,
	output logic                 tick
);
	logic [3:0] pre_q;
	logic       o1_q;
	logic       o2_q;
	logic       o3_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			pre_q <= 4'h0;
		else if ((sel == cca_pkg::CCA_TB_DIV12 && pre_q == `CCA_DIV12) ||
			 (sel == cca_pkg::CCA_TB_DIV4 && pre_q >= `CCA_DIV4))
			pre_q <= 4'h0;
		else
			pre_q <= pre_q + 4'h1;
	end

	// Oscillator/8 level is resynchronised; its rising edge counts
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			o1_q <= 1'b0;
			o2_q <= 1'b0;
			o3_q <= 1'b0;
		end else begin
			o1_q <= osc_div8;
			o2_q <= o1_q;
			o3_q <= o2_q;
		end
	end

	always_comb begin
		unique case (sel)
			cca_pkg::CCA_TB_DIV12: tick = (pre_q == `CCA_DIV12);
			cca_pkg::CCA_TB_DIV4:  tick = (pre_q >= `CCA_DIV4);
			cca_pkg::CCA_TB_T0OVF: tick = t0_ovf;
			cca_pkg::CCA_TB_EXTIN: tick = ext_fall;
			cca_pkg::CCA_TB_SYS:   tick = 1'b1;
			cca_pkg::CCA_TB_OSC8:  tick = o2_q && !o3_q;
			default:               tick = 1'b0;
		endcase
	end
endmodule // cca_tick
`default_nettype wire

// ==== hdl/cca_top.sv ====
// Operation
// - 16-bit counter, low read snapshots high
// - Counter reads never disturb counting
// - Timebase select picks increment source
// - External input counts on falling edges
// - Oscillator/8 timebase resynchronised to clock
// - Wrap sets overflow flag, gated interrupt
// - Overflow flag cleared only by software
// - Interrupts need global and group enables
// - Idle suspend clear: count during idle
// - Five 16-bit modules, each with line
// - Capture edge chosen by rise/fall bits
// - Mode bits select output and PWM modes
// - Module enable gates flag interrupt request
// - Capture copies counter into module value
// - Capture sets module flag, software clears
// - Input pulses under two clocks ignored
// - Software timer match sets module flag
// - Software timer: compare and match set
// - Low write clears, high write sets compare
// - Module 4 guard timer active after reset
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cca_defs.svh"
module cca_top #(
	parameter int NMOD = 5
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic [31:0]           prdata,
	output logic                  pslverr,
	input  wire logic             global_irq_enable,
	input  wire logic             array_group_irq_enable,
	input  wire logic             cpu_idle,
	input  wire logic             t0_ovf,
	input  wire logic             ext_count_input,
	input  wire logic             osc_div8,
	input  wire logic [NMOD-1:0]  module_io_in,
	output logic [NMOD-1:0]       module_io_line,
	output logic                  irq,
	output logic                  guard_reset
);
	logic [15:0]       cnt_q;
	logic [7:0]        snap_q;
	logic              ovf_q;
	logic              ovf_ie_q;
	logic [2:0]        tb_q;
	logic              idle_sus_q;
	logic              guard_q;
	logic              run_q;
	logic [NMOD-1:0]   mflag_q;
	logic [7:0]        mmode_q [NMOD];
	logic [15:0]       mval_q  [NMOD];
	logic [NMOD-1:0]   out_q;
	logic [NMOD-1:0]   rise_p;
	logic [NMOD-1:0]   fall_p;
	logic              ext_fall;
	logic              tick;
	logic              step;
	logic              wrap;
	logic              wr;
	logic              rd;
	logic [31:0]       rdata_d;
	logic              hit_d;
	logic              ovf_req;
	logic              mod_req;

	// Writes land in the access cycle; reads are sampled in setup so prdata is a flop
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	function automatic cca_pkg::cca_mode_t mode_of(input logic [7:0] m);
		if (!m[`CCA_MM_MAT] && !m[`CCA_MM_TOG] && !m[`CCA_MM_PWM] &&
		    (m[`CCA_MM_RISE] || m[`CCA_MM_FALL]))
			return cca_pkg::CCA_M_CAPTURE;
		if (!m[`CCA_MM_CMP])
			return cca_pkg::CCA_M_OFF;
		if (m[`CCA_MM_TOG] && m[`CCA_MM_PWM])
			return cca_pkg::CCA_M_FREQ;
		if (m[`CCA_MM_PWM])
			return m[`CCA_MM_WIDE] ? cca_pkg::CCA_M_PWM16 : cca_pkg::CCA_M_PWM8;
		if (m[`CCA_MM_MAT])
			return m[`CCA_MM_TOG] ? cca_pkg::CCA_M_HSOUT : cca_pkg::CCA_M_SWTIMER;
		return cca_pkg::CCA_M_OFF;
	endfunction

	// Address is an argument: a continuous assignment only wakes on its operands
	function automatic logic at(input logic [11:0] ad, input logic [11:0] base,
		input int i);
		return ad == base + 12'(i * 4);
	endfunction

	cca_edge u_eci (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.raw_in  (ext_count_input),
		.rise_p  (),
		.fall_p  (ext_fall)
	);

	cca_tick u_tick (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.sel      (cca_pkg::cca_tb_t'(tb_q)),
		.t0_ovf   (t0_ovf),
		.ext_fall (ext_fall),
		.osc_div8 (osc_div8),
		.tick     (tick)
	);

	// Guard timer forces the counter on; idle suspend gates it
	assign step = tick && (run_q || guard_q) && !(idle_sus_q && cpu_idle);
	// Wrap follows a step, so a software load of all ones raises no flag
	assign wrap = step && cnt_q == `CCA_ONES16;

	// Count writes are refused while the guard runs
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			cnt_q <= `CCA_ZERO16;
		else if (wr && !guard_q && paddr == `CCA_A_CNT_LO)
			cnt_q <= {cnt_q[15:8], pwdata[7:0]};
		else if (wr && !guard_q && paddr == `CCA_A_CNT_HI)
			cnt_q <= {pwdata[7:0], cnt_q[7:0]};
		else if (step)
			cnt_q <= cnt_q + 16'h0001;
	end

	// Read strobe marks the setup cycle, when the low byte is sampled too, so a
	// carry between the two byte reads cannot tear the 16-bit value
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			snap_q <= `CCA_ZERO8;
		else if (rd && paddr == `CCA_A_CNT_LO)
			snap_q <= cnt_q[15:8];
	end

	// Mode register; timebase and idle bits freeze while guard runs
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ovf_ie_q   <= 1'b0;
			tb_q       <= 3'h0;
			idle_sus_q <= 1'b0;
			guard_q    <= 1'(`CCA_MODE_RST >> `CCA_MD_GUARD);
			run_q      <= 1'b0;
		end else if (wr && paddr == `CCA_A_MODE) begin
			ovf_ie_q <= pwdata[`CCA_MD_OVFIE];
			guard_q  <= pwdata[`CCA_MD_GUARD];
			if (!guard_q) begin
				tb_q       <= pwdata[`CCA_MD_TB_HI:`CCA_MD_TB_LO];
				idle_sus_q <= pwdata[`CCA_MD_IDLE];
			end
		end else if (wr && paddr == `CCA_A_CTRL) begin
			run_q <= pwdata[`CCA_CN_RUN];
		end
	end

	// Set wins over a simultaneous software clear
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			ovf_q <= 1'b0;
		else if (wrap)
			ovf_q <= 1'b1;
		else if (wr && (paddr == `CCA_A_MODE || paddr == `CCA_A_CTRL))
			ovf_q <= paddr == `CCA_A_MODE ? pwdata[`CCA_MD_OVF]
				: pwdata[`CCA_CN_OVF];
	end

	// One capture/compare unit per module line
	genvar g;
	generate
		for (g = 0; g < NMOD; g++) begin : g_mod
			cca_pkg::cca_mode_t md;
			logic               cap;
			logic               match;
			logic               lo_match;
			logic               lo_wr;
			logic               hi_wr;
			logic               guard_mod;

			assign guard_mod = guard_q && g == `CCA_GUARD_MOD;
			assign md = mode_of(mmode_q[g]);
			assign cap = md == cca_pkg::CCA_M_CAPTURE &&
				((mmode_q[g][`CCA_MM_RISE] && rise_p[g]) ||
				 (mmode_q[g][`CCA_MM_FALL] && fall_p[g]));
			assign match = step && cnt_q == mval_q[g];
			assign lo_match = step && cnt_q[7:0] == mval_q[g][7:0];
			assign lo_wr = wr && at(paddr, `CCA_A_MLO0, g);
			assign hi_wr = wr && at(paddr, `CCA_A_MHI0, g);

			cca_edge u_cex (
				.sys_clk (sys_clk),
				.sys_rst (sys_rst),
				.raw_in  (module_io_in[g]),
				.rise_p  (rise_p[g]),
				.fall_p  (fall_p[g])
			);

			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst)
					mmode_q[g] <= `CCA_ZERO8;
				else if (lo_wr)
					mmode_q[g][`CCA_MM_CMP] <= 1'b0;
				else if (hi_wr)
					mmode_q[g][`CCA_MM_CMP] <= 1'b1;
				else if (wr && at(paddr, `CCA_A_MMODE0, g) && !guard_mod)
					mmode_q[g] <= pwdata[7:0];
			end

			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst)
					mval_q[g] <= `CCA_ZERO16;
				// Guard refresh: high byte reloads with count high plus the offset
				else if (hi_wr && guard_mod)
					mval_q[g][15:8] <= cnt_q[15:8] + mval_q[g][7:0];
				else if (lo_wr)
					mval_q[g][7:0] <= pwdata[7:0];
				else if (hi_wr)
					mval_q[g][15:8] <= pwdata[7:0];
				else if (cap)
					mval_q[g] <= cnt_q;
				else if (md == cca_pkg::CCA_M_FREQ && lo_match)
					mval_q[g][7:0] <= mval_q[g][7:0] + mval_q[g][15:8];
				else if (md == cca_pkg::CCA_M_PWM8 && step && cnt_q[7:0] == 8'hFF)
					mval_q[g][7:0] <= mval_q[g][15:8];
			end

			// Flag: hardware set outranks a software clear in the same cycle
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst)
					mflag_q[g] <= 1'b0;
				else if (cap || (!guard_mod && match && mmode_q[g][`CCA_MM_MAT] &&
					 mmode_q[g][`CCA_MM_CMP]))
					mflag_q[g] <= 1'b1;
				else if (wr && paddr == `CCA_A_CTRL)
					mflag_q[g] <= pwdata[g];
			end

			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst)
					out_q[g] <= 1'b0;
				else if (guard_mod)
					out_q[g] <= 1'b0;
				else if ((md == cca_pkg::CCA_M_HSOUT && match) ||
					 (md == cca_pkg::CCA_M_FREQ && lo_match))
					out_q[g] <= !out_q[g];
				else if (md == cca_pkg::CCA_M_PWM8)
					out_q[g] <= (step && cnt_q[7:0] == 8'hFF) ? 1'b0 :
						(lo_match ? 1'b1 : out_q[g]);
				else if (md == cca_pkg::CCA_M_PWM16)
					out_q[g] <= wrap ? 1'b0 : (match ? 1'b1 : out_q[g]);
				else if (!mmode_q[g][`CCA_MM_CMP] && mmode_q[g][`CCA_MM_PWM])
					out_q[g] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			module_io_line <= '0;
		else
			module_io_line <= out_q;
	end

	// Guard reset: high-byte match at a low-byte wrap, or forced by writing flag
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			guard_reset <= 1'b0;
		else
			guard_reset <= guard_q &&
				((step && cnt_q[7:0] == 8'hFF &&
				  cnt_q[15:8] == mval_q[`CCA_GUARD_MOD][15:8]) ||
				 (wr && paddr == `CCA_A_CTRL && pwdata[`CCA_GUARD_MOD]));
	end

	logic [NMOD-1:0] ien;
	always_comb begin
		for (int i = 0; i < NMOD; i++)
			ien[i] = mmode_q[i][`CCA_MM_IRQ];
	end
	assign ovf_req = ovf_q && ovf_ie_q;
	assign mod_req = |(mflag_q & ien);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= global_irq_enable && array_group_irq_enable &&
				(ovf_req || mod_req);
	end

	// Unused register bits read as zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		hit_d   = 1'b1;
		if (paddr == `CCA_A_CNT_LO)
			rdata_d[7:0] = cnt_q[7:0];
		else if (paddr == `CCA_A_CNT_HI)
			rdata_d[7:0] = snap_q;
		else if (paddr == `CCA_A_MODE)
			rdata_d[7:0] = {idle_sus_q, 1'b0, guard_q, tb_q, ovf_ie_q, ovf_q};
		else if (paddr == `CCA_A_CTRL)
			rdata_d[7:0] = {ovf_q, run_q, 1'b0, 5'(mflag_q)};
		else begin
			hit_d = 1'b0;
			for (int i = 0; i < NMOD; i++) begin
				if (at(paddr, `CCA_A_MMODE0, i)) begin
					rdata_d[7:0] = mmode_q[i];
					hit_d = 1'b1;
				end
				if (at(paddr, `CCA_A_MLO0, i)) begin
					rdata_d[7:0] = mval_q[i][7:0];
					hit_d = 1'b1;
				end
				if (at(paddr, `CCA_A_MHI0, i)) begin
					rdata_d[7:0] = mval_q[i][15:8];
					hit_d = 1'b1;
				end
			end
		end
	end

	// Answer registered in the setup cycle so pready/prdata are flops
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= rd ? rdata_d : 32'h0000_0000;
			pslverr <= psel && !penable && !hit_d;
		end
	end
endmodule // cca_top
`default_nettype wire

// ==== test/cca_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module cca_chk #(
	parameter int NMOD = 5
) (
	input wire logic            sys_clk,
	input wire logic            sys_rst,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [11:0]     paddr,
	input wire logic [31:0]     pwdata,
	input wire logic            pready,
	input wire logic [31:0]     prdata,
	input wire logic            pslverr,
	input wire logic            global_irq_enable,
	input wire logic            array_group_irq_enable,
	input wire logic            cpu_idle,
	input wire logic            t0_ovf,
	input wire logic            ext_count_input,
	input wire logic            osc_div8,
	input wire logic [NMOD-1:0] module_io_in,
	input wire logic [NMOD-1:0] module_io_line,
	input wire logic            irq,
	input wire logic            guard_reset
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic wr_acc;
	logic guard_q;
	assign wr_acc = psel && penable && pready && pwrite;
	// Guard comes up enabled; only a mode register write changes it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			guard_q <= 1'b1;
		else if (wr_acc && paddr == 12'h008)
			guard_q <= pwdata[5];
	end
	bus_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("access phase without exactly one ready cycle");
	read_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data or error outside the access cycle");
	byte_data_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data above bit 7");
	unmapped_a: assert property (psel && penable && paddr == 12'h0FC |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	irq_gated_a: assert property (irq |-> $past(global_irq_enable && array_group_irq_enable))
		else $error("interrupt without both enables");
	irq_drop_a: assert property (!global_irq_enable |=> !irq)
		else $error("interrupt stayed up after global enable fell");
	guard_force_a: assert property (wr_acc && paddr == 12'h00C && pwdata[4] && guard_q |-> ##[1:2] guard_reset)
		else $error("forced guard reset missing");
	guard_pulse_a: assert property (guard_reset |=> !guard_reset)
		else $error("guard reset longer than one cycle");
	cover property (irq);
	cover property (pslverr);
	cover property (guard_reset);
endmodule // cca_chk
`default_nettype wire

// ==== test/cca_far.sv ====
`timescale 1ns/1ps
`default_nettype none
// Free-running stimulus on the count sources; module lines under bench control
module cca_far (
	input  wire logic  sys_clk,
	output logic       t0_ovf,
	output logic       ext_count_input,
	output logic       osc_div8,
	output logic [4:0] module_io_in
);
	logic [4:0] cnt_q = 5'h00;
	initial module_io_in = 5'h00;
	always_ff @(posedge sys_clk) begin
		cnt_q <= (cnt_q == 5'd23) ? 5'h00 : cnt_q + 5'h01;
	end
	assign t0_ovf = cnt_q[2:0] == 3'h0;
	// Falls every 8 clocks, twice the legal minimum spacing
	assign ext_count_input = cnt_q[2];
	assign osc_div8 = (cnt_q % 5'd12) < 5'd6;
	task automatic line(input int n, input logic v);
		@(posedge sys_clk);
		module_io_in[n] <= v;
	endtask
	// Inverts the line and holds it: both writes carry the value read before the first one lands
	task automatic glitch(input int n);
		line(n, ~module_io_in[n]);
		line(n, ~module_io_in[n]);
		repeat (3) @(posedge sys_clk);
	endtask
endmodule // cca_far
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb;
	localparam int NMOD = 5;
	localparam int PER [6] = '{12, 4, 8, 8, 1, 12};
	localparam logic [7:0] RATE_MODE [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h10, 8'h90};
	localparam logic [7:0] RATE_IDLE = 8'hC0;
	localparam logic [7:0] CAP_MODE [3] = '{8'h21, 8'h11, 8'h31};
	logic            sys_clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic [11:0]     paddr = 12'h000;
	logic [31:0]     pwdata = 32'h0;
	logic            global_irq_enable = 1'b0;
	logic            array_group_irq_enable = 1'b0;
	logic            cpu_idle = 1'b0;
	logic            pready, pslverr, irq, guard_reset, t0_ovf, ext_count_input, osc_div8;
	logic [31:0]     prdata, rd;
	logic [NMOD-1:0] module_io_in, module_io_line;
	logic            err, hit;
	logic            gr_seen = 1'b0;
	logic [7:0]      a;
	logic [15:0]     c, x;
	int              errors = 0;
	int              n_checks = 0;
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (guard_reset === 1'b1) gr_seen <= 1'b1;
	cca_far far_u (.sys_clk(sys_clk), .t0_ovf(t0_ovf), .ext_count_input(ext_count_input),
		.osc_div8(osc_div8), .module_io_in(module_io_in));
	cca_top #(.NMOD(NMOD)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
		.array_group_irq_enable(array_group_irq_enable), .cpu_idle(cpu_idle), .t0_ovf(t0_ovf),
		.ext_count_input(ext_count_input), .osc_div8(osc_div8), .module_io_in(module_io_in),
		.module_io_line(module_io_line), .irq(irq), .guard_reset(guard_reset));
	// Counts expected over a 48-clock window between two low-byte reads
	function automatic logic [7:0] ticks(input logic [7:0] md, input logic idle);
		return (idle && md[7]) ? 8'h00 : 8'(48 / PER[md[4:2]]);
	endfunction
	task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Waits as long as the slave needs; only the watchdog ends a hang
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [7:0] d);
		bus(1'b1, ad, {24'h0, d});
	endtask
	task automatic wr16(input logic [11:0] lo, input logic [11:0] hi, input logic [15:0] v);
		wr(lo, v[7:0]);
		wr(hi, v[15:8]);
	endtask
	task automatic wrap_up;
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#(20 * 40000);
		errors++;
		wrap_up();
	end
	initial begin
		c = 16'($urandom(9));
		x = 16'h0000;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		bus(1'b0, 12'h008, 32'h0);
		`CHK("mode reset", 8'h20, rd[7:0])
		wr(12'h000, 8'h55);
		bus(1'b0, 12'h000, 32'h0);
		`CHK("guarded count", 1'b1, rd[7:0] != 8'h55 && rd[7:0] < 8'h20)
		wr(12'h00C, 8'h10);
		repeat (2) @(posedge sys_clk);
		`CHK("guard pulse", 1'b1, gr_seen)
		bus(1'b0, 12'h0FC, 32'h0);
		`CHK("unmapped", 33'h100000000, {err, rd})
		wr(12'h008, 8'h00);
		wr(12'h00C, 8'h40);
		// Timebases in select order, then idle kept and idle stopped
		for (int i = 0; i < 8; i++) begin
			wr(12'h008, RATE_MODE[i]);
			cpu_idle <= RATE_IDLE[i];
			repeat (4) @(posedge sys_clk);
			bus(1'b0, 12'h000, 32'h0);
			a = rd[7:0];
			repeat (45) @(posedge sys_clk);
			bus(1'b0, 12'h000, 32'h0);
			`CHK("rate", ticks(RATE_MODE[i], RATE_IDLE[i]), 8'(rd[7:0] - a))
		end
		cpu_idle <= 1'b0;
		wr(12'h00C, 8'h00);
		wr(12'h008, 8'h10);
		wr16(12'h000, 12'h004, {c[15:8], 8'hF0});
		wr(12'h00C, 8'h40);
		bus(1'b0, 12'h000, 32'h0);
		repeat (40) @(posedge sys_clk);
		bus(1'b0, 12'h004, 32'h0);
		`CHK("snapshot", c[15:8], rd[7:0])
		bus(1'b0, 12'h000, 32'h0);
		bus(1'b0, 12'h004, 32'h0);
		`CHK("high after wrap", 8'(c[15:8] + 8'h01), rd[7:0])
		wr(12'h00C, 8'h00);
		wr(12'h008, 8'h12);
		wr16(12'h000, 12'h004, 16'hFFF8);
		wr(12'h00C, 8'h40);
		repeat (20) @(posedge sys_clk);
		`CHK("irq masked", 1'b0, irq)
		global_irq_enable <= 1'b1;
		array_group_irq_enable <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK("overflow irq", 1'b1, irq)
		wr(12'h00C, 8'h80);
		global_irq_enable <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK("irq global off", 1'b0, irq)
		global_irq_enable <= 1'b1;
		bus(1'b0, 12'h008, 32'h0);
		`CHK("overflow held", 1'b1, rd[0])
		wr(12'h008, 8'h10);
		bus(1'b0, 12'h008, 32'h0);
		`CHK("overflow cleared", 1'b0, rd[0])
		wr(12'h024, 8'h08);
		wr(12'h044, c[7:0]);
		bus(1'b0, 12'h024, 32'h0);
		`CHK("compare after low", 1'b0, rd[6])
		wr(12'h064, c[15:8]);
		bus(1'b0, 12'h024, 32'h0);
		`CHK("compare after high", 8'h48, rd[7:0])
		wr(12'h00C, 8'h00);
		wr16(12'h000, 12'h004, c - 16'd20);
		wr(12'h00C, 8'h40);
		repeat (40) @(posedge sys_clk);
		bus(1'b0, 12'h00C, 32'h0);
		`CHK("timer flag", 1'b1, rd[1])
		`CHK("timer irq off", 1'b0, irq)
		wr(12'h024, 8'h49);
		repeat (3) @(posedge sys_clk);
		`CHK("timer irq on", 1'b1, irq)
		wr(12'h00C, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(12'h020, CAP_MODE[i]);
			for (int e = 0; e < 2; e++) begin
				c = 16'($urandom);
				wr16(12'h000, 12'h004, c);
				wr(12'h00C, 8'h00);
				far_u.glitch(0);
				far_u.line(0, ~e[0]);
				repeat (8) @(posedge sys_clk);
				hit = CAP_MODE[i][5 - e];
				if (hit) x = c;
				bus(1'b0, 12'h00C, 32'h0);
				`CHK("capture flag", hit, rd[0])
				`CHK("capture irq", hit, irq)
				bus(1'b0, 12'h040, 32'h0);
				`CHK("capture low", x[7:0], rd[7:0])
				bus(1'b0, 12'h060, 32'h0);
				`CHK("capture high", x[15:8], rd[7:0])
			end
		end
		// High-speed output: one match in the window toggles the line once
		wr(12'h028, 8'h0C);
		wr16(12'h048, 12'h068, c + 16'd10);
		`CHK("hsout idle", 1'b0, module_io_line[2])
		wr(12'h00C, 8'h40);
		repeat (20) @(posedge sys_clk);
		`CHK("hsout line", 1'b1, module_io_line[2])
		wrap_up();
	end
endmodule // tb
bind cca_top cca_chk #(.NMOD(NMOD)) chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
	.array_group_irq_enable(array_group_irq_enable), .cpu_idle(cpu_idle), .t0_ovf(t0_ovf),
	.ext_count_input(ext_count_input), .osc_div8(osc_div8), .module_io_in(module_io_in),
	.module_io_line(module_io_line), .irq(irq), .guard_reset(guard_reset));
`default_nettype wire
